// file: design/sisp_pkg.sv
// Purpose: Shared constants and types for the sensor I2C slave port and its bus master.
// Assumes: Core clock at 125 MHz; open-drain lines are pulled up outside.
// Notes: Filter and divider counts derive from the printed times and the clock rate.
package sisp_pkg;

  // Core clock rate
  localparam int SISP_CORE_CLK_KHZ = 125000;

  // Glitch filter: a spike may cover one sample more than its whole cycles,
  // so the stable time is one sample beyond that
  localparam int SISP_FILT_NS = 50;
  localparam int SISP_FILT_CYC = (SISP_FILT_NS * SISP_CORE_CLK_KHZ) / 1000000 + 2;
  localparam logic [2:0] SISP_FILT_CNT_MAX = 3'(SISP_FILT_CYC - 1);

  // Bus speeds
  localparam int SISP_SCL_FAST_KHZ = 400;
  localparam int SISP_SCL_NORM_KHZ = 100;
  // Quarter bit period of the master, rounded up so SCL never exceeds the rate
  localparam int SISP_QTR_CYC = (SISP_CORE_CLK_KHZ + 4 * SISP_SCL_FAST_KHZ - 1) /
                                (4 * SISP_SCL_FAST_KHZ);

  // Byte framing
  localparam logic [3:0] SISP_BYTE_BITS = 4'h8;
  localparam logic [1:0] SISP_PHASE_LAST = 2'h3;

  // Slave addresses by strap pair {high, low}
  localparam logic [6:0] SISP_ADDR_SEL_00 = 7'h1e;
  localparam logic [6:0] SISP_ADDR_SEL_01 = 7'h1d;
  localparam logic [6:0] SISP_ADDR_SEL_10 = 7'h1c;
  localparam logic [6:0] SISP_ADDR_SEL_11 = 7'h1f;

  // Values after reset
  localparam logic [7:0] SISP_PTR_RST = 8'h00;

  // Master commands
  typedef enum logic [1:0] {
    SISP_CMD_START = 2'h0,
    SISP_CMD_WRITE = 2'h1,
    SISP_CMD_READ = 2'h2,
    SISP_CMD_STOP = 2'h3
  } sisp_cmd_t;

  function automatic logic [6:0] sisp_slave_addr(input logic sel_high, input logic sel_low);
    logic [6:0] a;
    a = SISP_ADDR_SEL_00;
    if (sel_high && sel_low)
      a = SISP_ADDR_SEL_11;
    else if (sel_high)
      a = SISP_ADDR_SEL_10;
    else if (sel_low)
      a = SISP_ADDR_SEL_01;
    return a;
  endfunction

endpackage

// file: design/sisp_if.sv
// Purpose: Two-wire bus between the slave port and the master.
// Assumes: Both lines are open drain with pull-ups; an enable means drive the pin's output.
// Notes: The wired-AND level is resolved here from the enables.
`timescale 1ns/1ps
interface sisp_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_scl_o;
  logic d_scl_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Open drain: only a driven low pulls the line down
  assign scl = ~((h_scl_oe & ~h_scl_o) | (d_scl_oe & ~d_scl_o));
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

  modport dev (
    input scl,
    input sda,
    output d_scl_o,
    output d_scl_oe,
    output d_sda_o,
    output d_sda_oe
  );

  modport host (
    input scl,
    input sda,
    output h_scl_o,
    output h_scl_oe,
    output h_sda_o,
    output h_sda_oe
  );
endinterface

// file: design/sisp_dev.sv
// Purpose: Slave end of the sensor I2C port; hands register writes on, fetches read bytes.
// Assumes: Register file answers i_rd_data for o_reg_ptr in the same clock domain.
// Notes: Never stretches SCL; a write byte meeting a full buffer is not acknowledged.
`timescale 1ns/1ps
module sisp_dev
  import sisp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Bus
  sisp_if.dev bus,
  // Address straps
  input wire logic i_addr_sel_low,
  input wire logic i_addr_sel_high,
  // Received words to the register file
  output logic o_rx_valid,
  output logic [15:0] o_rx_data,
  input wire logic i_rx_ready,
  // Read side
  output logic [7:0] o_reg_ptr,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_strobe,
  // Bus status
  output logic o_bus_busy,
  output logic o_bus_open_event,
  output logic o_resumed_open_event,
  output logic o_bus_close_event
);

  typedef enum logic [6:0] {
    DS_IDLE = 7'h01,
    DS_ADDR = 7'h02,
    DS_ACK = 7'h04,
    DS_WRITE = 7'h08,
    DS_READ = 7'h10,
    DS_RACK = 7'h20,
    DS_IGNORE = 7'h40
  } sisp_dstate_t;

  sisp_dstate_t state_reg;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [1:0] filt_reg;
  logic [1:0] prev_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic sda_oe_reg;
  logic scl_oe_reg;
  logic addr_phase_reg;
  logic matched_reg;
  logic rw_reg;
  logic reg_byte_reg;
  logic go_on_reg;
  logic push_reg;
  logic [15:0] wdata_reg;
  logic head_v_reg;
  logic [15:0] head_reg;
  logic tail_v_reg;
  logic [15:0] tail_reg;
  logic busy_reg;
  logic open_reg;
  logic resumed_reg;
  logic close_reg;

  // Two-flop synchronisers: scl, sda, straps
  wire [3:0] raw_in = {i_addr_sel_high, i_addr_sel_low, bus.sda, bus.scl};

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Filter delay far below SCL low time
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_filt
      logic [2:0] fcnt_reg;
      logic lvl_reg;
      always_ff @(posedge i_core_clk)
      begin
        if (i_srst)
        begin
          lvl_reg <= 1'b1;
          fcnt_reg <= 3'h0;
        end
        else if (sync2_reg[gi] == lvl_reg)
          fcnt_reg <= 3'h0;
        else if (fcnt_reg == SISP_FILT_CNT_MAX)
        begin
          lvl_reg <= sync2_reg[gi];
          fcnt_reg <= 3'h0;
        end
        else
          fcnt_reg <= fcnt_reg + 3'h1;
      end
    end
  endgenerate

  // One driver for both filtered levels
  assign filt_reg = {g_filt[1].lvl_reg, g_filt[0].lvl_reg};

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      prev_reg <= 2'h3;
    else
      prev_reg <= filt_reg;
  end

  // Line events from filtered levels
  wire scl_f = filt_reg[0];
  wire sda_f = filt_reg[1];
  wire scl_rise = scl_f & ~prev_reg[0];
  wire scl_fall = ~scl_f & prev_reg[0];
  wire start_det = scl_f & prev_reg[0] & prev_reg[1] & ~sda_f;
  wire stop_det = scl_f & prev_reg[0] & ~prev_reg[1] & sda_f;
  wire byte_done = scl_fall & (cnt_reg == SISP_BYTE_BITS);
  wire [6:0] own_addr = sisp_slave_addr(sync2_reg[3], sync2_reg[2]);
  wire addr_hit = (sh_reg[7:1] == own_addr);
  wire buf_ready = ~tail_v_reg;
  wire pop = head_v_reg & i_rx_ready;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_reg <= DS_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= SISP_PTR_RST;
      sda_oe_reg <= 1'b0;
      addr_phase_reg <= 1'b0;
      matched_reg <= 1'b0;
      rw_reg <= 1'b0;
      reg_byte_reg <= 1'b0;
      go_on_reg <= 1'b0;
      push_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      busy_reg <= 1'b0;
      open_reg <= 1'b0;
      resumed_reg <= 1'b0;
      close_reg <= 1'b0;
      o_rd_strobe <= 1'b0;
    end
    else
    begin
      push_reg <= 1'b0;
      open_reg <= 1'b0;
      resumed_reg <= 1'b0;
      close_reg <= 1'b0;
      o_rd_strobe <= 1'b0;
      if (stop_det)
      begin
        state_reg <= DS_IDLE;
        busy_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
        close_reg <= 1'b1;
      end
      else if (start_det)
      begin
        state_reg <= DS_ADDR;
        busy_reg <= 1'b1;
        cnt_reg <= 4'h0;
        sda_oe_reg <= 1'b0;
        addr_phase_reg <= 1'b1;
        open_reg <= ~busy_reg;
        resumed_reg <= busy_reg;
      end
      else
      begin
        case (state_reg)
          DS_ADDR, DS_WRITE:
          begin
            if (scl_rise)
            begin
              sh_reg <= {sh_reg[6:0], sda_f};
              cnt_reg <= cnt_reg + 4'h1;
            end
            else if (byte_done)
            begin
              cnt_reg <= 4'h0;
              state_reg <= DS_ACK;
              if (state_reg == DS_ADDR)
              begin
                rw_reg <= sh_reg[0];
                matched_reg <= addr_hit;
                sda_oe_reg <= addr_hit;
                reg_byte_reg <= ~sh_reg[0];
              end
              else if (reg_byte_reg)
              begin
                ptr_reg <= sh_reg;
                reg_byte_reg <= 1'b0;
                sda_oe_reg <= 1'b1;
              end
              else
              begin
                // No stretching possible, so a full buffer answers with no acknowledge
                sda_oe_reg <= buf_ready;
                push_reg <= buf_ready;
                wdata_reg <= {ptr_reg, sh_reg};
                if (buf_ready)
                  ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          DS_ACK:
          begin
            if (scl_fall)
            begin
              sda_oe_reg <= 1'b0;
              addr_phase_reg <= 1'b0;
              if (addr_phase_reg && !matched_reg)
                state_reg <= DS_IGNORE;
              else if (addr_phase_reg && rw_reg)
              begin
                state_reg <= DS_READ;
                tx_reg <= i_rd_data;
                sda_oe_reg <= ~i_rd_data[7];
                o_rd_strobe <= 1'b1;
              end
              else
                state_reg <= DS_WRITE;
            end
          end
          DS_READ:
          begin
            if (scl_rise)
              cnt_reg <= cnt_reg + 4'h1;
            else if (byte_done)
            begin
              sda_oe_reg <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= DS_RACK;
            end
            else if (scl_fall)
            begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
          DS_RACK:
          begin
            if (scl_rise)
            begin
              go_on_reg <= ~sda_f;
              ptr_reg <= ptr_reg + 8'h01;
            end
            else if (scl_fall)
            begin
              if (go_on_reg)
              begin
                state_reg <= DS_READ;
                tx_reg <= i_rd_data;
                sda_oe_reg <= ~i_rd_data[7];
                o_rd_strobe <= 1'b1;
              end
              else
                state_reg <= DS_IGNORE;
            end
          end
          default:
          begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Two-entry buffer: head feeds the port, tail catches a word during a stall
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= 16'h0000;
      tail_reg <= 16'h0000;
    end
    else if (pop && tail_v_reg)
    begin
      head_reg <= tail_reg;
      tail_v_reg <= 1'b0;
    end
    else if (pop)
    begin
      head_v_reg <= push_reg;
      head_reg <= wdata_reg;
    end
    else if (push_reg && !head_v_reg)
    begin
      head_v_reg <= 1'b1;
      head_reg <= wdata_reg;
    end
    else if (push_reg)
    begin
      tail_v_reg <= 1'b1;
      tail_reg <= wdata_reg;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
      scl_oe_reg <= 1'b0;
    else
      scl_oe_reg <= 1'b0;
  end

  assign bus.d_scl_o = 1'b0;
  assign bus.d_scl_oe = scl_oe_reg;
  assign bus.d_sda_o = 1'b0;
  assign bus.d_sda_oe = sda_oe_reg;
  assign o_rx_valid = head_v_reg;
  assign o_rx_data = head_reg;
  assign o_reg_ptr = ptr_reg;
  assign o_bus_busy = busy_reg;
  assign o_bus_open_event = open_reg;
  assign o_resumed_open_event = resumed_reg;
  assign o_bus_close_event = close_reg;

endmodule

// file: design/sisp_host.sv
// Purpose: Bus master end; turns start, write, read and stop commands into bus cycles.
// Assumes: Slave never stretches SCL, so the master runs open loop on its divider.
// Notes: SCL is held low between commands while the bus is owned.
`timescale 1ns/1ps
module sisp_host
  import sisp_pkg::*;
#(
  parameter int QTR_CYC = SISP_QTR_CYC
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Bus
  sisp_if.host bus,
  // Commands
  input wire logic i_cmd_valid,
  input wire sisp_cmd_t i_cmd,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_cmd_nack,
  output logic o_cmd_ready,
  // Results
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  output logic o_ack_seen,
  output logic o_bus_held
);

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_START = 4'h2,
    HS_BYTE = 4'h4,
    HS_STOP = 4'h8
  } sisp_hstate_t;

  localparam logic [11:0] QTR_MAX = 12'(QTR_CYC - 1);

  sisp_hstate_t state_reg;
  logic [11:0] div_reg;
  logic [1:0] phase_reg;
  logic [3:0] bit_reg;
  logic [7:0] tx_reg;
  logic [7:0] sh_reg;
  logic read_reg;
  logic nack_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic ready_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;

  wire tick = (div_reg == QTR_MAX);
  wire accept = i_cmd_valid & ready_reg;
  wire last_phase = tick & (phase_reg == SISP_PHASE_LAST);
  wire ack_bit = (bit_reg == SISP_BYTE_BITS);
  // Release on write ack, drive low to acknowledge reads
  wire bit_low = ack_bit ? (read_reg & ~nack_reg) : (~read_reg & ~tx_reg[7]);

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      div_reg <= 12'h000;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end
    else
    begin
      div_reg <= tick ? 12'h000 : div_reg + 12'h001;
      sda_s1_reg <= bus.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      state_reg <= HS_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      tx_reg <= 8'h00;
      sh_reg <= 8'h00;
      read_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      ready_reg <= 1'b1;
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
      o_ack_seen <= 1'b0;
      o_bus_held <= 1'b0;
    end
    else
    begin
      o_rd_valid <= 1'b0;
      if (tick && state_reg != HS_IDLE)
        phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        HS_IDLE:
        begin
          if (accept)
          begin
            ready_reg <= 1'b0;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            tx_reg <= i_cmd_data;
            read_reg <= (i_cmd == SISP_CMD_READ);
            nack_reg <= i_cmd_nack;
            if (i_cmd == SISP_CMD_START)
              state_reg <= HS_START;
            else if (i_cmd == SISP_CMD_STOP)
              state_reg <= HS_STOP;
            else
              state_reg <= HS_BYTE;
          end
        end
        HS_START:
        begin
          if (tick)
          begin
            if (phase_reg == 2'h0)
              sda_low_reg <= 1'b0;
            else if (phase_reg == 2'h1)
              scl_low_reg <= 1'b0;
            else if (phase_reg == 2'h2)
              sda_low_reg <= 1'b1;
            else
            begin
              scl_low_reg <= 1'b1;
              o_bus_held <= 1'b1;
              state_reg <= HS_IDLE;
              ready_reg <= 1'b1;
            end
          end
        end
        HS_BYTE:
        begin
          // Nine clocks per byte, MSB first
          if (tick)
          begin
            if (phase_reg == 2'h0)
              sda_low_reg <= bit_low;
            else if (phase_reg == 2'h1)
              scl_low_reg <= 1'b0;
            else if (phase_reg == 2'h2)
            begin
              if (ack_bit)
                o_ack_seen <= ~sda_s2_reg;
              else
                sh_reg <= {sh_reg[6:0], sda_s2_reg};
            end
            else
            begin
              scl_low_reg <= 1'b1;
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
              if (ack_bit)
              begin
                // Last read byte left unacknowledged by command
                sda_low_reg <= 1'b0;
                o_rd_data <= sh_reg;
                o_rd_valid <= read_reg;
                state_reg <= HS_IDLE;
                ready_reg <= 1'b1;
              end
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            if (phase_reg == 2'h0)
              sda_low_reg <= 1'b1;
            else if (phase_reg == 2'h1)
              scl_low_reg <= 1'b0;
            else if (phase_reg == 2'h2)
              sda_low_reg <= 1'b0;
            else
            begin
              o_bus_held <= 1'b0;
              state_reg <= HS_IDLE;
              ready_reg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign bus.h_scl_o = 1'b0;
  assign bus.h_scl_oe = scl_low_reg;
  assign bus.h_sda_o = 1'b0;
  assign bus.h_sda_oe = sda_low_reg;
  assign o_cmd_ready = ready_reg;

endmodule

// file: verification/sisp_bus_checker.sv
// Purpose: Wire-level checks on the two-wire bus between slave port and master.
// Assumes: Both ends run on one core clock; SCL is slow against that clock.
// Notes: Start, stop and bit position are rebuilt here from the resolved lines.
`timescale 1ns/1ps
module sisp_bus_checker (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Bus signals
  input wire logic scl,
  input wire logic sda,
  input wire logic d_scl_oe,
  input wire logic d_sda_oe,
  input wire logic h_scl_oe
);
  logic scl_reg, sda_reg, busy_reg, first_reg, rd_reg;
  logic [3:0] bit_reg;
  logic [4:0] idle_reg;
  wire scl_rise = scl & ~scl_reg;
  wire scl_fall = ~scl & scl_reg;
  wire open_w = scl & scl_reg & sda_reg & ~sda;
  wire close_w = scl & scl_reg & ~sda_reg & sda;
  wire [3:0] bit_next = (bit_reg == 4'h9) ? 4'h1 : bit_reg + 4'h1;
  wire [4:0] idle_next = busy_reg ? 5'h00 : ((idle_reg == 5'h1f) ? idle_reg : idle_reg + 5'h01);

  // Raw line levels; the bus here carries no glitches
  always_ff @(posedge i_core_clk)
  begin
    scl_reg <= i_srst | scl;
    sda_reg <= i_srst | sda;
    idle_reg <= i_srst ? 5'h00 : idle_next;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst | close_w)
      busy_reg <= 1'b0;
    else if (open_w)
      busy_reg <= 1'b1;
    if (i_srst | open_w)
      bit_reg <= 4'h0;
    else if (scl_rise)
      bit_reg <= bit_next;
    if (i_srst)
      first_reg <= 1'b0;
    else if (open_w)
      first_reg <= 1'b1;
    else if (scl_fall && bit_reg == 4'h9)
      first_reg <= 1'b0;
    if (i_srst)
      rd_reg <= 1'b0;
    else if (scl_rise && first_reg && bit_reg == 4'h7)
      rd_reg <= sda;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_no_clock_stretch: assert property (!d_scl_oe)
    else $error("slave pulled the clock line");
  a_idle_lines_released: assert property (idle_reg == 5'h1f |-> !(d_sda_oe || h_scl_oe))
    else $error("line driven while bus idle");
  a_ack_steady_high: assert property (scl && $past(scl) |-> $stable(d_sda_oe))
    else $error("slave data moved during clock high");
  a_no_false_condition: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("slave data changed with clock high");
  a_addr_not_driven: assert property (scl_rise && first_reg && bit_reg != 4'h8 |-> !d_sda_oe)
    else $error("slave drove during address bits");
  a_wr_bits_released: assert property (
    scl_rise && !first_reg && !rd_reg && bit_reg != 4'h8 |-> !d_sda_oe)
    else $error("slave drove during written data bits");
  a_rd_ack_released: assert property (scl_rise && !first_reg && rd_reg && bit_reg == 4'h8
    |-> !d_sda_oe)
    else $error("slave drove during master ack slot");
  a_ack_release_time: assert property (scl_fall && bit_reg == 4'h9 && !rd_reg
    |-> ##[1:16] !d_sda_oe)
    else $error("slave held ack past its slot");
endmodule

// file: verification/sensor_i2c_slave_port_tb.sv
// Purpose: Self-checking bench joining master and slave port over the bus.
// Assumes: Master quarter period shortened to 8 cycles; register file modelled here.
// Notes: A second slave on its own bus is bit-banged for glitch filtering.
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module sensor_i2c_slave_port_tb
  import sisp_pkg::*;
;
  logic core_clk, srst, sel_low, sel_high, rx_ready, hold_off, cmd_valid, cmd_nack, owned;
  sisp_cmd_t cmd;
  logic [7:0] cmd_data, reg_ptr, host_rd, mem [256];
  logic [15:0] rx_data;
  logic [16:0] exp_w;
  logic rx_valid, bus_busy, ev_open, ev_res, ev_close, g_open_ev, g_close_ev;
  logic cmd_ready, ack_seen, rd_valid, rd_strobe, bus_held;
  int n_rdv, n_strb, e_rd;
  logic [15:0] exp_q [$];
  int n_errors, n_checks, cyc, n_open, n_res, n_close, g_open, g_close, e_open, e_res, e_close;
  wire logic [7:0] reg_rd = mem[reg_ptr];
  sisp_if bus_if();
  sisp_if glitch_if();

  sisp_dev sisp_dev_i (.i_core_clk(core_clk), .i_srst(srst), .bus(bus_if.dev),
    .i_addr_sel_low(sel_low), .i_addr_sel_high(sel_high), .o_rx_valid(rx_valid),
    .o_rx_data(rx_data), .i_rx_ready(rx_ready), .o_reg_ptr(reg_ptr), .i_rd_data(reg_rd),
    .o_rd_strobe(rd_strobe), .o_bus_busy(bus_busy), .o_bus_open_event(ev_open),
    .o_resumed_open_event(ev_res), .o_bus_close_event(ev_close));
  sisp_host #(.QTR_CYC(8)) sisp_host_i (.i_core_clk(core_clk), .i_srst(srst),
    .bus(bus_if.host), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_data(cmd_data),
    .i_cmd_nack(cmd_nack), .o_cmd_ready(cmd_ready), .o_rd_data(host_rd),
    .o_rd_valid(rd_valid), .o_ack_seen(ack_seen), .o_bus_held(bus_held));
  sisp_bus_checker sisp_bus_checker_i (.i_core_clk(core_clk), .i_srst(srst),
    .scl(bus_if.scl), .sda(bus_if.sda), .d_scl_oe(bus_if.d_scl_oe),
    .d_sda_oe(bus_if.d_sda_oe), .h_scl_oe(bus_if.h_scl_oe));
  // Never written through, so its buffer may stay open
  sisp_dev sisp_dev_glitch_i (.i_core_clk(core_clk), .i_srst(srst), .bus(glitch_if.dev),
    .i_addr_sel_low(sel_low), .i_addr_sel_high(sel_high), .o_rx_valid(), .o_rx_data(),
    .i_rx_ready(1'b1), .o_reg_ptr(), .i_rd_data(reg_rd), .o_rd_strobe(), .o_bus_busy(),
    .o_bus_open_event(g_open_ev), .o_resumed_open_event(), .o_bus_close_event(g_close_ev));

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (e !== g)
    begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    n_open += int'(ev_open);
    n_res += int'(ev_res);
    n_close += int'(ev_close);
    g_open += int'(g_open_ev);
    g_close += int'(g_close_ev);
    n_rdv += int'(rd_valid);
    n_strb += int'(rd_strobe);
    if (!srst && rx_valid === 1'b1 && rx_ready)
    begin
      exp_w = (exp_q.size() > 0) ? {1'b0, exp_q.pop_front()} : 17'h1ffff;
      `CHK("rx word", exp_w, rx_data);
      mem[rx_data[15:8]] = rx_data[7:0];
    end
    if (cyc == 80000)
    begin
      n_errors++;
      finish_test();
    end
    else
      #1 rx_ready = hold_off ? 1'b0 : ($urandom % 4 != 0);
  end

  function automatic logic [6:0] exp_addr(input int s);
    return (s == 0) ? 7'h1e : (s == 1) ? 7'h1d : (s == 2) ? 7'h1c : 7'h1f;
  endfunction

  // Request held from just after an edge until the edge that takes it
  task automatic send(input sisp_cmd_t c, input logic [7:0] d, input logic nk);
    int n;
    e_open += int'(c == SISP_CMD_START && !owned);
    e_res += int'(c == SISP_CMD_START && owned);
    e_close += int'(c == SISP_CMD_STOP);
    e_rd += int'(c == SISP_CMD_READ);
    owned = (c == SISP_CMD_START) | (owned & (c != SISP_CMD_STOP));
    cmd = c;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(posedge core_clk);
    #1 cmd_valid = 1'b0;
    n = 0;
    @(posedge core_clk);
    while (cmd_ready !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      n++;
    end
    // Hung master counts as a mismatch
    if (n >= 3000)
      n_errors++;
    #1;
  endtask

  task automatic stop_bus();
    send(SISP_CMD_STOP, 8'h00, 1'b0);
    repeat (16) @(posedge core_clk);
    #1;
    `CHK("busy after stop", 1'b0, bus_busy);
    `CHK("held after stop", 1'b0, bus_held);
  endtask

  task automatic wr_xfer(input logic [6:0] a, input logic [7:0] r, input int n, input logic ok);
    logic [7:0] d;
    send(SISP_CMD_START, 8'h00, 1'b0);
    send(SISP_CMD_WRITE, {a, 1'b0}, 1'b0);
    `CHK("addr ack", ok, ack_seen);
    if (ok)
    begin
      send(SISP_CMD_WRITE, r, 1'b0);
      `CHK("reg ack", 1'b1, ack_seen);
      for (int i = 0; i < n; i++)
      begin
        d = 8'($urandom);
        // Expectation queued first: the word may pop during the ack slot
        if (!(hold_off && i >= 2))
          exp_q.push_back({r + 8'(i), d});
        send(SISP_CMD_WRITE, d, 1'b0);
        `CHK("data ack", !(hold_off && i >= 2), ack_seen);
      end
    end
    `CHK("busy", 1'b1, bus_busy);
    `CHK("held", 1'b1, bus_held);
    stop_bus();
  endtask

  task automatic rd_xfer(input logic [6:0] a, input logic [7:0] r, input int n);
    send(SISP_CMD_START, 8'h00, 1'b0);
    send(SISP_CMD_WRITE, {a, 1'b0}, 1'b0);
    send(SISP_CMD_WRITE, r, 1'b0);
    send(SISP_CMD_START, 8'h00, 1'b0);
    `CHK("busy kept", 1'b1, bus_busy);
    send(SISP_CMD_WRITE, {a, 1'b1}, 1'b0);
    `CHK("read addr ack", 1'b1, ack_seen);
    for (int i = 0; i < n; i++)
    begin
      send(SISP_CMD_READ, 8'h00, i == n - 1);
      `CHK("read data", mem[r + 8'(i)], host_rd);
    end
    stop_bus();
  endtask

  task automatic pulse_sda(input logic lvl, input int cycles);
    glitch_if.h_sda_oe = lvl;
    repeat (cycles) @(posedge core_clk);
    #1 glitch_if.h_sda_oe = ~lvl;
    repeat (20) @(posedge core_clk);
    #1;
  endtask

  initial
  begin
    {srst, sel_low, sel_high, rx_ready, hold_off, cmd_valid, cmd_nack, owned} = 8'h80;
    cmd = SISP_CMD_START;
    cmd_data = 8'h00;
    {glitch_if.h_scl_o, glitch_if.h_sda_o, glitch_if.h_scl_oe, glitch_if.h_sda_oe} = 4'h0;
    void'($urandom(32'ha7f8));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    repeat (16) @(posedge core_clk);
    #1 srst = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    pulse_sda(1'b1, 6);
    `CHK("glitch start", 0, g_open);
    glitch_if.h_sda_oe = 1'b1;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK("real start", 1, g_open);
    // High spike inside the held start
    pulse_sda(1'b0, 6);
    `CHK("glitch stop", 0, g_close);
    glitch_if.h_sda_oe = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    `CHK("real stop", 1, g_close);
    for (int s = 0; s < 4; s++)
    begin
      {sel_high, sel_low} = 2'(s);
      repeat (4) @(posedge core_clk);
      #1;
      wr_xfer(exp_addr(s), 8'h20 + 8'(s), 1, 1'b1);
      wr_xfer(exp_addr(s) ^ 7'h01, 8'h30, 2, 1'b0);
    end
    wr_xfer(7'h1f, 8'hfe, 3, 1'b1);
    rd_xfer(7'h1f, 8'hfe, 3);
    repeat (3)
    begin
      logic [7:0] rg;
      rg = 8'($urandom);
      wr_xfer(7'h1f, rg, 1 + $urandom % 6, 1'b1);
      rd_xfer(7'h1f, rg, 1 + $urandom % 6);
    end
    hold_off = 1'b1;
    wr_xfer(7'h1f, 8'h40, 3, 1'b1);
    hold_off = 1'b0;
    repeat (16) @(posedge core_clk);
    #1;
    `CHK("buffer drained", 0, exp_q.size());
    rd_xfer(7'h1f, 8'h40, 3);
    `CHK("open events", e_open, n_open);
    `CHK("resumed events", e_res, n_res);
    `CHK("close events", e_close, n_close);
    `CHK("read valids", e_rd, n_rdv);
    `CHK("read strobes", e_rd, n_strb);
    finish_test();
  end
endmodule
